// *** design/wit_timer.sv ***
////////////////////////////////////////////////////////////////////////////
module wit_timer #(
  parameter int PRS_W = wit_pkg::PRS_W,
  parameter int CNT_W = wit_pkg::CNT_W
) (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic [wit_pkg::ADDR_W-1:0] addr,
  input  wire logic                       wrEn,
  input  wire logic [wit_pkg::DATA_W-1:0] wrData,
  input  wire logic                       bitWrEn,
  input  wire logic [2:0]                 bitIdx,
  input  wire logic                       bitVal,
  input  wire logic                       rdEn,
  output logic      [wit_pkg::DATA_W-1:0] rdData_q,
  input  wire logic                       subClk,
  output logic                            watchPeriodIrq_q,
  output logic                            intervalPeriodIrq_q
);
  import wit_pkg::*;

  logic [DATA_W-1:0] mode_q;
  logic [PRS_W-1:0]  prs_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              subClk_q;
  logic              divTick;
  logic              watchTick;
  logic              fwxTick;
  logic              intervalHit;
  logic              watchHit;
  logic              hit;
  logic              enable;
  logic              run;
  logic [2:0]        isel;
  logic [1:0]        wsel;

  function automatic logic [PRS_W-1:0] tapMask(input logic [2:0] code);
    tapMask = PRS_W'((1 << (INT_BASE_EXP + int'(code))) - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode register
  assign hit    = (addr == MODE_ADDR);
  assign enable = mode_q[BIT_ENABLE];
  assign run    = mode_q[BIT_RUN];
  assign isel   = mode_q[ISEL_LSB +: 3];
  assign wsel   = mode_q[WSEL_LSB +: 2];

  // Byte write wins if both strobes land together
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mode_q <= MODE_RESET;
    else if (wrEn && hit)
      mode_q <= wrData;
    else if (bitWrEn && hit)
      mode_q[bitIdx] <= bitVal;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdData_q <= '0;
    else if (rdEn && hit)
      rdData_q <= mode_q;
    else
      rdData_q <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watch clock source
  wit_clk_div #(.DIV(DIV_RATIO)) u_div (
    .clk    (clk),
    .arst_n (arst_n),
    .tick_q (divTick)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      subClk_q <= 1'b0;
    else
      subClk_q <= subClk;
  end

  // Subclock must be slower than half of clk to be edge sampled
  assign watchTick = mode_q[BIT_CLKSEL] ? (subClk && !subClk_q)
                                        : divTick;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and 5-bit counter
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prs_q <= '0;
    else if (!enable)
      prs_q <= '0;
    else if (watchTick)
      prs_q <= prs_q + PRS_W'(1);
  end

  assign intervalHit = enable && watchTick
                       && ((prs_q & tapMask(isel)) == tapMask(isel));

  // Long periods count fw/2^9, short ones count fw directly
  assign fwxTick = wsel[1] ? watchTick
                 : (watchTick && (&prs_q[FWX_EXP-1:0]));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= '0;
    else if (!(enable && run))
      cnt_q <= '0;
    else if (fwxTick)
      cnt_q <= cnt_q + CNT_W'(1);
  end

  assign watchHit = enable && run && fwxTick
                    && (wsel[0] ? (&cnt_q[SHORT_CNT_W-1:0])
                                : (&cnt_q));

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulses
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      intervalPeriodIrq_q <= 1'b0;
    else
      intervalPeriodIrq_q <= intervalHit;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      watchPeriodIrq_q <= 1'b0;
    else
      watchPeriodIrq_q <= watchHit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Register access
  byte_write_a: assert property (
    wrEn && hit |=> mode_q == $past(wrData))
    else $error("byte write not stored");
  bit_write_a: assert property (
    bitWrEn && hit && !wrEn
    |=> mode_q[$past(bitIdx)] == $past(bitVal))
    else $error("bit write not stored");
  bit_keep_a: assert property (
    bitWrEn && hit && !wrEn
    |=> ((mode_q ^ $past(mode_q))
         & ~(DATA_W'(1) << $past(bitIdx))) == '0)
    else $error("bit write touched other bits");
  miss_hold_a: assert property (
    !hit |=> $stable(mode_q))
    else $error("foreign address changed mode");
  read_back_a: assert property (
    rdEn && hit |=> rdData_q == $past(mode_q))
    else $error("read data wrong");

  // Prescaler and counter
  stop_clears_a: assert property (
    !enable |=> prs_q == '0 && cnt_q == '0)
    else $error("stop did not clear");
  run_clear_a: assert property (
    enable && !run && !wrEn && !bitWrEn
    |=> cnt_q == '0
        && prs_q == $past(prs_q) + PRS_W'($past(watchTick)))
    else $error("counter clear disturbed prescaler");
  prs_hold_a: assert property (
    enable && !watchTick |=> $stable(prs_q))
    else $error("prescaler moved without tick");
  long_step_a: assert property (
    enable && run && !wsel[1]
    && !(watchTick && (&prs_q[FWX_EXP-1:0])) |=> $stable(cnt_q))
    else $error("long counter moved off the wrap");
  long_wrap_a: assert property (
    enable && run && !wsel[1] && watchTick && (&prs_q[FWX_EXP-1:0])
    |=> cnt_q == $past(cnt_q) + CNT_W'(1))
    else $error("long counter missed the wrap");

  // Interrupt requests
  interval_tap_a: assert property (
    enable && watchTick && isel == 3'h0 && prs_q[3:0] == 4'hf
    |=> intervalPeriodIrq_q)
    else $error("interval tap missed");
  ivl_gate_a: assert property (
    intervalPeriodIrq_q |-> $past(enable))
    else $error("interval request while stopped");
  irq_pulse_a: assert property (
    watchPeriodIrq_q |=> !watchPeriodIrq_q)
    else $error("watch request longer than one cycle");
  watch_gate_a: assert property (
    watchPeriodIrq_q |-> $past(enable && run))
    else $error("watch request while counter stopped");
  ivl_pulse_a: assert property (
    intervalPeriodIrq_q |=> !intervalPeriodIrq_q)
    else $error("interval request longer than one cycle");

  // Main scenarios
  interval_seen_c: cover property (intervalPeriodIrq_q);
  watch_seen_c: cover property (watchPeriodIrq_q);
  both_seen_c: cover property (watchPeriodIrq_q && intervalPeriodIrq_q);
  sub_clock_c: cover property (mode_q[BIT_CLKSEL] && intervalPeriodIrq_q);
  long_wrap_c: cover property (enable && run && !wsel[1] && fwxTick);
endmodule

// *** include/wit_pkg.sv ***
package wit_pkg;
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 8;
  localparam logic [15:0] MODE_ADDR    = 16'hff6f;
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam int          BIT_ENABLE   = 0;
  localparam int          BIT_RUN      = 1;
  localparam int          WSEL_LSB     = 2;
  localparam int          ISEL_LSB     = 4;
  localparam int          BIT_CLKSEL   = 7;
  localparam int          PRS_W        = 11;
  localparam int          CNT_W        = 5;
  localparam int          DIV_RATIO    = 128;
  localparam int          INT_BASE_EXP = 4;
  localparam int          FWX_EXP      = 9;
  localparam int          SHORT_CNT_W  = 4;
endpackage

// *** design/wit_clk_div.sv ***
module wit_clk_div #(
  parameter int DIV = wit_pkg::DIV_RATIO
) (
  input  wire logic clk,
  input  wire logic arst_n,
  output logic      tick_q
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] divCnt_q;

  // Free running so the watch clock phase is independent of enable
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      divCnt_q <= '0;
    else if (divCnt_q == LAST)
      divCnt_q <= '0;
    else
      divCnt_q <= divCnt_q + W'(1);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tick_q <= 1'b0;
    else
      tick_q <= (divCnt_q == LAST);
  end
endmodule

// *** test/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wit_pkg::*;
  logic              clk;
  logic              arst_n;
  logic [ADDR_W-1:0] addr;
  logic              wrEn;
  logic [DATA_W-1:0] wrData;
  logic              bitWrEn;
  logic [2:0]        bitIdx;
  logic              bitVal;
  logic              rdEn;
  logic [DATA_W-1:0] rdData_q;
  logic              subClk;
  logic              watchIrq;
  logic              intIrq;
  logic [1:0]        subCnt;
  logic [7:0]        rv;
  int                n;
  int                errCount;
  int                checksDone;
  ////////////////////////////////////////////////////////////////////////////
  wit_timer i_dut (.clk, .arst_n, .addr, .wrEn, .wrData, .bitWrEn, .bitIdx,
    .bitVal, .rdEn, .rdData_q, .subClk, .watchPeriodIrq_q(watchIrq),
    .intervalPeriodIrq_q(intIrq));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Sub clock at clk/4, so one watch tick every 4 clk cycles
  always @(posedge clk)
  begin
    subCnt <= subCnt + 2'd1;
    subClk <= subCnt[1];
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic endSim();
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp, input string what);
    checksDone++;
    if (seen !== exp)
    begin
      errCount++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic [15:0] a, input bit w, b,
                     input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    bitIdx <= d[2:0];
    bitVal <= d[7];
    wrEn <= w & ~b;
    bitWrEn <= w & b;
    rdEn <= ~w;
    @(posedge clk);
    {wrEn, bitWrEn, rdEn} <= 3'b000;
    #1 rv = rdData_q;
  endtask
  // Bounded wait for a pulse; a hang ends the run
  task automatic waitPulse(input bit w);
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
      if (n > 20000)
      begin
        check(0, 1, "pulse wait");
        endSim();
      end
    end while ((w ? watchIrq : intIrq) !== 1'b1);
  endtask
  task automatic period(input logic [7:0] m, input bit w, input int exp);
    acc(MODE_ADDR, 1, 0, m);
    waitPulse(w);
    @(posedge clk);
    #1 check(w ? watchIrq : intIrq, 0, "pulse width");
    waitPulse(w);
    check(n + 1, exp, "period");
    acc(MODE_ADDR, 1, 0, 8'h00);
  endtask
  task automatic quiet(input logic [7:0] m, input bit w);
    acc(MODE_ADDR, 1, 0, m);
    n = 0;
    repeat (300)
    begin
      @(posedge clk);
      #1 n += ((w ? watchIrq : intIrq) === 1'b1);
    end
    check(n, 0, "stopped pulses");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {arst_n, wrEn, bitWrEn, bitVal, rdEn, subCnt} = '0;
    {addr, wrData, bitIdx, errCount, checksDone} = '0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    acc(MODE_ADDR, 0, 0, 8'h00);
    check(rv, MODE_RESET, "reset mode");
    acc(MODE_ADDR, 1, 0, 8'h5a);
    acc(MODE_ADDR, 1, 1, 8'h01); // Bit 1 cleared
    acc(MODE_ADDR, 1, 1, 8'h87); // Bit 7 set
    acc(MODE_ADDR, 0, 0, 8'h00);
    check(rv, 8'hd8, "mode readback");
    acc(16'h0000, 1, 0, 8'hff); // Foreign write must not land
    acc(16'h0000, 0, 0, 8'h00);
    check(rv, 8'h00, "unmapped read");
    acc(MODE_ADDR, 0, 0, 8'h00);
    check(rv, 8'hd8, "mode after foreign write");
    acc(MODE_ADDR, 1, 0, 8'h00);
    // Long watch code keeps the 5-bit counter busy meanwhile
    for (int c = 0; c < 8; c++)
      period({1'b1, c[2:0], 4'b0011}, 0, 4 << (4 + c));
    period(8'h8f, 1, 64);
    period(8'h8b, 1, 128);
    period(8'h01, 0, 16 * DIV_RATIO);
    quiet(8'h8d, 1);
    // Reset in mid-run must drop a running mode
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    acc(MODE_ADDR, 0, 0, 8'h00);
    check(rv, MODE_RESET, "mode after reset");
    quiet(8'h8e, 0);
    endSim();
  end
endmodule
